// File: design/sgc_pkg.sv
package sgc_pkg;

  // Word indices on the internal module bus
  localparam logic [3:0] SGC_ADDR_CFG    = 4'h0;
  localparam logic [3:0] SGC_ADDR_INTR   = 4'h2;
  localparam logic [3:0] SGC_ADDR_PORT   = 4'h4;
  localparam logic [3:0] SGC_ADDR_PINCTL = 4'h5;

  // Module configuration word fields
  localparam int SGC_CFG_STOP_BIT = 15;
  localparam int SGC_CFG_FREEZE_HALT_ENABLE_BIT = 14;
  localparam int SGC_CFG_FRZ0_BIT = 13;
  localparam int SGC_CFG_ARB_LSB  = 0;
  localparam int SGC_ARB_W        = 4;

  // Interrupt level byte fields
  localparam int SGC_LVL_W         = 3;
  localparam int SGC_LVL_SPI_LSB   = 3;
  localparam int SGC_LVL_ASYNC_LSB = 0;

  // Reset values
  localparam logic                 SGC_STOP_RST  = 1'b1;
  localparam logic [SGC_ARB_W-1:0] SGC_ARB_RST   = 4'h0;
  localparam logic [5:0]           SGC_LVL_RST   = 6'h00;
  localparam logic [7:0]           SGC_VEC_RST   = 8'h0F;
  localparam logic [7:0]           SGC_BYTE_RST  = 8'h00;

  // Pin positions in the eight-bit port
  localparam int SGC_PIN_MISO = 0;
  localparam int SGC_PIN_MOSI = 1;
  localparam int SGC_PIN_SCK  = 2;
  localparam int SGC_PIN_PCS0 = 3;
  localparam int SGC_PIN_PCS1 = 4;
  localparam int SGC_PIN_TXD  = 7;

  typedef struct packed {
    logic       master;
    logic       enable;
    logic       mosi;
    logic       miso;
    logic       sck;
    logic [3:0] pcs;
  } sgc_spi_out_t;

  typedef struct packed {
    logic miso;
    logic mosi;
    logic sck;
    logic ss_n;
  } sgc_spi_in_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } sgc_pins_t;

endpackage

// File: design/sgc_pinmux.sv
`timescale 1ns/1ps
module sgc_pinmux
  import sgc_pkg::*;
(
  input  wire logic [7:0]   pin_assign,  // Pin assignment byte
  input  wire logic [7:0]   pin_dir,     // Pin direction byte
  input  wire logic [7:0]   port_data,   // Latched port data
  input  wire logic [7:0]   pin_in,      // Pin levels
  input  wire sgc_spi_out_t spi,         // SPI core outputs
  input  wire logic         tx_enable,   // Async transmitter enabled
  input  wire logic         txd,         // Async transmit data
  output sgc_pins_t         pins,        // Pin drive
  output sgc_spi_in_t       spi_rx,      // SPI core inputs
  output logic              mode_fault   // Select asserted as master input
);

  logic [7:0] spi_own;
  logic [7:0] spi_out;
  logic [7:0] spi_oe;
  logic       mst;

  assign mst = spi.master;
  // Serial clock pin stays general I/O until SPI enable is set
  assign spi_own = {1'b0, pin_assign[6:3], pin_assign[2] & spi.enable, pin_assign[1:0]};

  assign spi_out = {1'b0, spi.pcs, spi.sck, spi.mosi, spi.miso};
  // Master drives MOSI/SCK/selects, slave drives MISO, each gated by its direction bit
  assign spi_oe  = {1'b0,
                    pin_dir[6:4] & {3{mst}},
                    pin_dir[3] & mst,
                    pin_dir[2] & mst,
                    pin_dir[1] & mst,
                    pin_dir[0] & ~mst};

  // Transmitter enable overrides direction on the TXD pin
  assign pins.out[6:0] = (spi_own[6:0] & spi_out[6:0]) | (~spi_own[6:0] & port_data[6:0]);
  assign pins.oe[6:0]  = (spi_own[6:0] & spi_oe[6:0]) | (~spi_own[6:0] & pin_dir[6:0]);
  assign pins.out[7]   = tx_enable ? txd : port_data[7];
  assign pins.oe[7]    = tx_enable | pin_dir[7];

  // Unused inputs idle high so the core sees no activity
  assign spi_rx.miso = (spi_own[0] & mst & ~pin_dir[0]) ? pin_in[0] : 1'b1;
  assign spi_rx.mosi = (spi_own[1] & ~mst & ~pin_dir[1]) ? pin_in[1] : 1'b1;
  assign spi_rx.sck  = (spi_own[2] & ~mst & ~pin_dir[2]) ? pin_in[2] : 1'b1;
  assign spi_rx.ss_n = (spi_own[3] & ~mst & ~pin_dir[3]) ? pin_in[3] : 1'b1;
  assign mode_fault  = spi_own[3] & mst & ~pin_dir[3] & ~pin_in[3];

endmodule

// File: design/sgc_top.sv
`timescale 1ns/1ps
//Contract
// - Unimplemented bits ignore writes, read zero
// - Stop bit gates module clock off
// - Stopped: only config readable, writes work
// - Stop set by CPU write and reset
// - Upper freeze bit halts SPI at boundary
// - Level field picks request line, zero disables
// - Equal levels: SPI request wins
// - Acknowledge compares priority mask with level
// - Arbitrate serially with nonzero arbitration number
// - Vector bits 7:1 stored, bit0 names source
// - Vector resets to 0F
// - Vector bit0 ignores writes, reads one
// - Assign bit: clear GPIO, set SPI
// - Direction bit: clear input, set output
// - Paired eight-bit registers share word addresses
// - Transmitter enable forces TXD output
// - Port writes drive outputs, reads sample pins
// - SPI data, clock pins gated by direction
// - Select pin: output, mode fault, slave select
// - Clock pin GPIO until SPI enabled
module sgc_top
  import sgc_pkg::*;
(
  input  wire logic         clk,               // 25 MHz system clock
  input  wire logic         reset_n,           // Synchronous reset, active low
  input  wire logic         bus_sel,           // Bus access request
  input  wire logic         bus_wr,            // Write when high
  input  wire logic [3:0]   bus_addr,          // Word index
  input  wire logic [1:0]   bus_be,            // Byte strobes: 1 upper, 0 lower
  input  wire logic [15:0]  bus_wdata,         // Write data
  output logic [15:0]       bus_rdata_r,       // Read data
  output logic              bus_ack_r,         // Access done pulse
  output logic              module_clk_en_r,   // Clock enable to serial module
  input  wire logic         freeze,            // Debug freeze
  input  wire logic         spi_boundary,      // SPI transfer boundary pulse
  output logic              spi_freeze_halt_r, // Halt request to SPI
  input  wire logic         spi_irq_req,       // SPI request level
  input  wire logic         async_irq_req,     // Async request level
  output logic [7:1]        irq_n_r,           // Request lines, active low
  input  wire logic         iack_start,        // Acknowledge cycle start pulse
  input  wire logic [2:0]   priority_mask,     // Mask from address bus
  input  wire logic         arb_in,            // Shared arbitration line level
  output logic              arb_drive_r,       // Arbitration bit drive
  output logic [7:0]        vec_data_r,        // Vector number
  output logic              vec_valid_r,       // Vector on data bus pulse
  input  wire sgc_spi_out_t spi_out,           // SPI core pin outputs
  input  wire logic         tx_enable,         // Async transmitter enabled
  input  wire logic         txd,               // Async transmit data
  input  wire logic [7:0]   pin_in,            // Port pin levels
  output sgc_pins_t         pins_r,            // Pin drive and enables
  output sgc_spi_in_t       spi_in_r,          // Inputs to SPI core
  output logic              mode_fault_r       // Mode fault level
);

  typedef enum logic [1:0] {SGC_IDLE, SGC_ARB} sgc_arb_state_t;

  logic                 stop_r;
  logic                 freeze_halt_enable_r;
  logic                 frz0_r;
  logic [SGC_ARB_W-1:0] arb_num_r;
  logic [5:0]           level_r;
  logic [7:1]           vec_hi_r;
  logic [7:0]           assign_r;
  logic [7:0]           dir_r;
  logic [7:0]           port_r;
  sgc_arb_state_t       state_r;
  logic [1:0]           bit_cnt_r;
  logic                 src_spi_r;

  wire logic wr_en   = bus_sel & bus_wr;
  wire logic rd_en   = bus_sel & ~bus_wr;
  wire logic wr_cfg  = wr_en & (bus_addr == SGC_ADDR_CFG);
  wire logic wr_intr = wr_en & (bus_addr == SGC_ADDR_INTR);
  wire logic wr_port = wr_en & (bus_addr == SGC_ADDR_PORT);
  wire logic wr_pin  = wr_en & (bus_addr == SGC_ADDR_PINCTL);

  function automatic logic [7:1] sgc_line(input logic [2:0] lvl);
    logic [7:1] v;
    v = 7'h00;
    for (int i = 1; i < 8; i++) begin
      if (lvl == 3'(i)) begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction

  // Configuration: stop sets from reset and clears only by software
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stop_r    <= SGC_STOP_RST;
      freeze_halt_enable_r    <= 1'b0;
      frz0_r    <= 1'b0;
      arb_num_r <= SGC_ARB_RST;
    end else begin
      if (wr_cfg && bus_be[1]) begin
        stop_r <= bus_wdata[SGC_CFG_STOP_BIT];
        freeze_halt_enable_r <= bus_wdata[SGC_CFG_FREEZE_HALT_ENABLE_BIT];
        frz0_r <= bus_wdata[SGC_CFG_FRZ0_BIT];
      end
      if (wr_cfg && bus_be[0]) begin
        arb_num_r <= bus_wdata[SGC_CFG_ARB_LSB +: SGC_ARB_W];
      end
    end
  end

  // Level in upper byte, vector in lower byte of one word
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      level_r  <= SGC_LVL_RST;
      vec_hi_r <= SGC_VEC_RST[7:1];
    end else begin
      if (wr_intr && bus_be[1]) begin
        level_r <= bus_wdata[13:8];
      end
      if (wr_intr && bus_be[0]) begin
        vec_hi_r <= bus_wdata[7:1];
      end
    end
  end

  // Assignment in upper byte, direction in lower byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      assign_r <= SGC_BYTE_RST;
      dir_r    <= SGC_BYTE_RST;
      port_r   <= SGC_BYTE_RST;
    end else begin
      if (wr_pin && bus_be[1]) begin
        assign_r <= bus_wdata[15:8];
      end
      if (wr_pin && bus_be[0]) begin
        dir_r <= bus_wdata[7:0];
      end
      if (wr_port && bus_be[0]) begin
        port_r <= bus_wdata[7:0];
      end
    end
  end

  // Read mux; gated-off module answers zero except configuration
  wire logic [15:0] cfg_word  = {stop_r, freeze_halt_enable_r, frz0_r, 9'h000, arb_num_r};
  wire logic [15:0] intr_word = {2'h0, level_r, vec_hi_r, 1'b1};
  wire logic [15:0] port_word = {8'h00, pin_in};
  wire logic [15:0] pin_word  = {assign_r, dir_r};
  logic [15:0] rd_word;
  always_comb begin
    unique case (bus_addr)
      SGC_ADDR_CFG:    rd_word = cfg_word;
      SGC_ADDR_INTR:   rd_word = stop_r ? 16'h0000 : intr_word;
      SGC_ADDR_PORT:   rd_word = stop_r ? 16'h0000 : port_word;
      SGC_ADDR_PINCTL: rd_word = stop_r ? 16'h0000 : pin_word;
      default:         rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_rdata_r <= 16'h0000;
      bus_ack_r   <= 1'b0;
    end else begin
      bus_ack_r   <= bus_sel;
      bus_rdata_r <= rd_en ? rd_word : 16'h0000;
    end
  end

  // Clock gate follows the stop bit one cycle later
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      module_clk_en_r <= 1'b0;
    end else begin
      module_clk_en_r <= ~stop_r;
    end
  end

  // Lower freeze bit is deliberately unused
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spi_freeze_halt_r <= 1'b0;
    end else if (!freeze) begin
      spi_freeze_halt_r <= 1'b0;
    end else if (freeze_halt_enable_r && spi_boundary) begin
      spi_freeze_halt_r <= 1'b1;
    end
  end

  // Requests follow the source levels, untouched by lost arbitration
  wire logic [2:0] spi_lvl   = level_r[SGC_LVL_SPI_LSB +: SGC_LVL_W];
  wire logic [2:0] async_lvl = level_r[SGC_LVL_ASYNC_LSB +: SGC_LVL_W];
  wire logic [2:0] spi_eff   = spi_irq_req ? spi_lvl : 3'h0;
  wire logic [2:0] async_eff = async_irq_req ? async_lvl : 3'h0;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_n_r <= 7'h7F;
    end else begin
      irq_n_r <= ~(sgc_line(spi_eff) | sgc_line(async_eff));
    end
  end

  // Tie of equal levels goes to SPI
  wire logic       pick_spi  = (spi_eff != 3'h0) && (spi_eff >= async_eff);
  wire logic [2:0] req_lvl   = pick_spi ? spi_eff : async_eff;
  wire logic       contend_w = (req_lvl > priority_mask) && (arb_num_r != SGC_ARB_RST);
  wire logic       lose_w    = arb_in & ~arb_drive_r;

  // Serial arbitration, most significant bit first, then one vector cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r     <= SGC_IDLE;
      bit_cnt_r   <= 2'h0;
      arb_drive_r <= 1'b0;
      src_spi_r   <= 1'b0;
      vec_valid_r <= 1'b0;
      vec_data_r  <= 8'h00;
    end else begin
      vec_valid_r <= 1'b0;
      unique case (state_r)
        SGC_IDLE: begin
          arb_drive_r <= 1'b0;
          if (iack_start && contend_w) begin
            state_r     <= SGC_ARB;
            bit_cnt_r   <= 2'h3;
            arb_drive_r <= arb_num_r[3];
            src_spi_r   <= pick_spi;
          end
        end
        SGC_ARB: begin
          if (lose_w) begin
            state_r     <= SGC_IDLE;
            arb_drive_r <= 1'b0;
          end else if (bit_cnt_r == 2'h0) begin
            state_r     <= SGC_IDLE;
            arb_drive_r <= 1'b0;
            vec_valid_r <= 1'b1;
            vec_data_r  <= {vec_hi_r, src_spi_r};
          end else begin
            bit_cnt_r   <= bit_cnt_r - 2'h1;
            arb_drive_r <= arb_num_r[bit_cnt_r - 2'h1];
          end
        end
        default: begin
          state_r <= SGC_IDLE;
        end
      endcase
    end
  end

  sgc_pins_t   pins_w;
  sgc_spi_in_t spi_in_w;
  logic        fault_w;

  sgc_pinmux u_pinmux (
    .pin_assign (assign_r),
    .pin_dir    (dir_r),
    .port_data  (port_r),
    .pin_in     (pin_in),
    .spi        (spi_out),
    .tx_enable  (tx_enable),
    .txd        (txd),
    .pins       (pins_w),
    .spi_rx     (spi_in_w),
    .mode_fault (fault_w)
  );

  // Pins register one cycle late; port data reset to zero avoids junk drive
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pins_r       <= '0;
      spi_in_r     <= '1;
      mode_fault_r <= 1'b0;
    end else begin
      pins_r       <= pins_w;
      spi_in_r     <= spi_in_w;
      mode_fault_r <= fault_w;
    end
  end

  logic [3:0] addr_q;
  logic       rd_q;
  logic       stop_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_q <= 4'h0;
      rd_q   <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      addr_q <= bus_addr;
      rd_q   <= rd_en;
      stop_q <= stop_r;
    end
  end

  property p_unimp_zero;
    @(posedge clk) disable iff (!reset_n)
      (bus_ack_r && rd_q && addr_q == SGC_ADDR_INTR) |-> bus_rdata_r[15:14] == 2'h0;
  endproperty
  a_unimp_zero: assert property (p_unimp_zero) else $error("unimplemented bits nonzero");

  property p_clk_gate;
    @(posedge clk) disable iff (!reset_n)
      stop_r |=> !module_clk_en_r;
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("clock not gated in stop");

  property p_stop_read;
    @(posedge clk) disable iff (!reset_n)
      (bus_ack_r && rd_q && stop_q && addr_q != SGC_ADDR_CFG) |-> bus_rdata_r == 16'h0000;
  endproperty
  a_stop_read: assert property (p_stop_read) else $error("register readable in stop");

  property p_reset_stop;
    @(posedge clk) !reset_n |=> stop_r;
  endproperty
  a_reset_stop: assert property (p_reset_stop) else $error("stop not set by reset");

  property p_freeze;
    @(posedge clk) disable iff (!reset_n)
      (freeze && freeze_halt_enable_r && spi_boundary) |=> spi_freeze_halt_r;
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze halt missing");

  property p_irq7;
    @(posedge clk) disable iff (!reset_n)
      (spi_irq_req && spi_lvl == 3'h7) |=> !irq_n_r[7];
  endproperty
  a_irq7: assert property (p_irq7) else $error("level seven line not asserted");

  sequence s_clean_arb;
    (iack_start && contend_w && state_r == SGC_IDLE) ##1 (!lose_w)[*4];
  endsequence
  property p_arb_win;
    @(posedge clk) disable iff (!reset_n)
      s_clean_arb |=> (vec_valid_r && vec_data_r[7:1] == vec_hi_r);
  endproperty
  a_arb_win: assert property (p_arb_win) else $error("uncontested arbitration gave no vector");

  property p_vec_src;
    @(posedge clk) disable iff (!reset_n)
      vec_valid_r |-> vec_data_r[0] == src_spi_r;
  endproperty
  a_vec_src: assert property (p_vec_src) else $error("vector lsb not source");

  property p_vec_lsb;
    @(posedge clk) disable iff (!reset_n)
      (bus_ack_r && rd_q && !stop_q && addr_q == SGC_ADDR_INTR) |-> bus_rdata_r[0];
  endproperty
  a_vec_lsb: assert property (p_vec_lsb) else $error("vector lsb read not one");

  property p_txd;
    @(posedge clk) disable iff (!reset_n)
      tx_enable |=> (pins_r.oe[SGC_PIN_TXD] && pins_r.out[SGC_PIN_TXD] == $past(txd));
  endproperty
  a_txd: assert property (p_txd) else $error("txd not forced out");

  property p_port_rd;
    @(posedge clk) disable iff (!reset_n)
      (rd_en && !stop_r && bus_addr == SGC_ADDR_PORT) |=> bus_rdata_r[7:0] == $past(pin_in);
  endproperty
  a_port_rd: assert property (p_port_rd) else $error("port read not pin levels");

endmodule

// File: verif/sgc_cpu_model.sv
`timescale 1ns/1ps
module sgc_cpu_model (
  input  wire logic        clk,           // System clock
  output logic             bus_sel,       // Access request
  output logic             bus_wr,        // Write when high
  output logic [3:0]       bus_addr,      // Word index
  output logic [1:0]       bus_be,        // Byte strobes
  output logic [15:0]      bus_wdata,     // Write data
  input  wire logic [15:0] bus_rdata_r,   // Read data
  input  wire logic        bus_ack_r,     // Access done
  output logic             iack_start,    // Acknowledge start
  output logic [2:0]       priority_mask, // Mask on address bus
  input  wire logic        arb_in,        // Resolved arbitration line
  input  wire logic [7:0]  vec_data_r,    // Vector number
  input  wire logic        vec_valid_r,   // Vector valid
  output logic             rival_drive    // Other module arbitration bit
);
  initial begin
    bus_sel = 1'b0;
    bus_wr = 1'b0;
    bus_addr = 4'h0;
    bus_be = 2'b00;
    bus_wdata = 16'h0000;
    iack_start = 1'b0;
    priority_mask = 3'h7;
    rival_drive = 1'b0;
  end

  // One-cycle request; released lines carry inverted data so stale values cannot pass
  task automatic access(input logic w, input logic [3:0] a, input logic [1:0] be,
                        input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk);
    #1;
    bus_sel = 1'b1;
    bus_wr = w;
    bus_addr = a;
    bus_be = be;
    bus_wdata = d;
    @(posedge clk);
    #1;
    bus_sel = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
    n = 0;
    // Acknowledge and read data stand for the cycle after the taking edge
    while (bus_ack_r !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    q = (bus_ack_r === 1'b1) ? bus_rdata_r : 16'hXXXX;
  endtask

  // A rival module arbitrates bit by bit and drops out when outvoted
  task automatic iack(input logic [2:0] mask, input logic [3:0] rival,
                      output logic got, output logic [7:0] vec);
    logic on;
    on = (rival != 4'h0);
    @(posedge clk);
    #1;
    iack_start = 1'b1;
    priority_mask = mask;
    @(posedge clk);
    #1;
    iack_start = 1'b0;
    priority_mask = ~mask;
    for (int i = 3; i >= 0; i--) begin
      rival_drive = on & rival[i];
      @(posedge clk);
      if (arb_in === 1'b1 && !rival[i]) on = 1'b0;
      #1;
    end
    rival_drive = 1'b0;
    // Vector pulse stands in the cycle after the last arbitration bit
    got = vec_valid_r;
    vec = vec_data_r;
  endtask
endmodule

// File: verif/tb_sgc_top.sv
`timescale 1ns/1ps
module tb_sgc_top;
  import sgc_pkg::*;
  logic         clk, reset_n, bus_sel, bus_wr, bus_ack_r, module_clk_en_r;
  logic         freeze, spi_boundary, spi_freeze_halt_r, spi_irq_req, async_irq_req;
  logic         iack_start, arb_in, arb_drive_r, vec_valid_r, tx_enable, txd;
  logic         mode_fault_r, rival_drive;
  logic [3:0]   bus_addr;
  logic [1:0]   bus_be;
  logic [15:0]  bus_wdata, bus_rdata_r;
  logic [7:1]   irq_n_r;
  logic [2:0]   priority_mask;
  logic [7:0]   vec_data_r, pin_in;
  sgc_spi_out_t spi_out;
  sgc_pins_t    pins_r;
  sgc_spi_in_t  spi_in_r;
  int           err_count, n_checks;

  sgc_top u_sgc_top (
    .clk(clk), .reset_n(reset_n), .bus_sel(bus_sel), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata),
    .bus_rdata_r(bus_rdata_r), .bus_ack_r(bus_ack_r), .module_clk_en_r(module_clk_en_r),
    .freeze(freeze), .spi_boundary(spi_boundary), .spi_freeze_halt_r(spi_freeze_halt_r),
    .spi_irq_req(spi_irq_req), .async_irq_req(async_irq_req), .irq_n_r(irq_n_r),
    .iack_start(iack_start), .priority_mask(priority_mask), .arb_in(arb_in),
    .arb_drive_r(arb_drive_r), .vec_data_r(vec_data_r), .vec_valid_r(vec_valid_r),
    .spi_out(spi_out), .tx_enable(tx_enable), .txd(txd), .pin_in(pin_in),
    .pins_r(pins_r), .spi_in_r(spi_in_r), .mode_fault_r(mode_fault_r)
  );

  sgc_cpu_model u_sgc_cpu_model (
    .clk(clk), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata_r(bus_rdata_r),
    .bus_ack_r(bus_ack_r), .iack_start(iack_start), .priority_mask(priority_mask),
    .arb_in(arb_in), .vec_data_r(vec_data_r), .vec_valid_r(vec_valid_r),
    .rival_drive(rival_drive)
  );

  // Wired-OR arbitration line shared with the rival
  assign arb_in = arb_drive_r | rival_drive;

  always #20 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
    logic [15:0] q;
    u_sgc_cpu_model.access(1'b1, a, be, d, q);
  endtask

  task automatic rd(input string s, input logic [3:0] a, input logic [15:0] e);
    logic [15:0] q;
    u_sgc_cpu_model.access(1'b0, a, 2'b00, 16'h0000, q);
    check(s, q, e);
  endtask

  task automatic t_stop;
    rd("cfg reset", SGC_ADDR_CFG, 16'h8000);
    check("clk en reset", 16'(module_clk_en_r), 16'h0000);
    wr(SGC_ADDR_CFG, 2'b11, 16'h0005);
    tick(2);
    check("clk en run", 16'(module_clk_en_r), 16'h0001);
    rd("vector reset", SGC_ADDR_INTR, 16'h000F);
    tx_enable = 1'b0;
    wr(SGC_ADDR_CFG, 2'b11, 16'h8005);
    tick(2);
    check("clk en stop", 16'(module_clk_en_r), 16'h0000);
    rd("cfg stopped", SGC_ADDR_CFG, 16'h8005);
    rd("intr stopped", SGC_ADDR_INTR, 16'h0000);
    wr(SGC_ADDR_INTR, 2'b11, 16'h2A40);
    wr(SGC_ADDR_CFG, 2'b11, 16'h0005);
    rd("write while stopped", SGC_ADDR_INTR, 16'h2A41);
    $display("t_stop done");
  endtask

  task automatic t_regs;
    wr(SGC_ADDR_INTR, 2'b11, 16'hFFFF);
    rd("intr ones", SGC_ADDR_INTR, 16'h3FFF);
    wr(SGC_ADDR_PINCTL, 2'b10, 16'hA5C3);
    rd("assign byte", SGC_ADDR_PINCTL, 16'hA500);
    wr(SGC_ADDR_PINCTL, 2'b01, 16'h00C3);
    rd("both bytes", SGC_ADDR_PINCTL, 16'hA5C3);
    wr(4'hF, 2'b11, 16'hFFFF);
    rd("unmapped", 4'hF, 16'h0000);
    wr(SGC_ADDR_CFG, 2'b11, 16'h7FF5);
    rd("cfg loose bits", SGC_ADDR_CFG, 16'h6005);
    wr(SGC_ADDR_PINCTL, 2'b11, 16'h0000);
    $display("t_regs done");
  endtask

  task automatic t_irq;
    logic       g;
    logic [7:0] v;
    spi_irq_req = 1'b1;
    for (int l = 0; l < 8; l++) begin
      wr(SGC_ADDR_INTR, 2'b10, {2'b00, 3'(l), 3'b000, 8'h00});
      tick(2);
      check("irq line", 16'(irq_n_r),
            (l == 0) ? 16'h007F : {9'h000, ~(7'h01 << (l - 1))});
    end
    wr(SGC_ADDR_INTR, 2'b11, 16'h2D40);
    async_irq_req = 1'b1;
    tick(2);
    u_sgc_cpu_model.iack(3'd4, 4'h0, g, v);
    check("tie vector", {7'h00, g, v}, 16'h0141);
    u_sgc_cpu_model.iack(3'd5, 4'h0, g, v);
    check("masked", 16'(g), 16'h0000);
    spi_irq_req = 1'b0;
    tick(2);
    u_sgc_cpu_model.iack(3'd4, 4'h0, g, v);
    check("async vector", {7'h00, g, v}, 16'h0140);
    u_sgc_cpu_model.iack(3'd4, 4'h7, g, v);
    check("lost", 16'(g), 16'h0000);
    check("held req", 16'(irq_n_r), 16'h006F);
    u_sgc_cpu_model.iack(3'd4, 4'h4, g, v);
    check("won", {7'h00, g, v}, 16'h0140);
    wr(SGC_ADDR_CFG, 2'b01, 16'h0000);
    u_sgc_cpu_model.iack(3'd4, 4'h0, g, v);
    check("zero arb number", 16'(g), 16'h0000);
    wr(SGC_ADDR_CFG, 2'b01, 16'h0005);
    async_irq_req = 1'b0;
    $display("t_irq done");
  endtask

  task automatic t_freeze;
    freeze = 1'b1;
    tick(3);
    check("no boundary", 16'(spi_freeze_halt_r), 16'h0000);
    spi_boundary = 1'b1;
    tick(1);
    spi_boundary = 1'b0;
    tick(1);
    check("halt", 16'(spi_freeze_halt_r), 16'h0001);
    freeze = 1'b0;
    wr(SGC_ADDR_CFG, 2'b11, 16'h2005);
    tick(1);
    freeze = 1'b1;
    spi_boundary = 1'b1;
    tick(1);
    spi_boundary = 1'b0;
    tick(1);
    check("lower bit", 16'(spi_freeze_halt_r), 16'h0000);
    freeze = 1'b0;
    $display("t_freeze done");
  endtask

  task automatic t_pins;
    wr(SGC_ADDR_PORT, 2'b01, 16'h00A5);
    wr(SGC_ADDR_PINCTL, 2'b11, 16'h000F);
    pin_in = 8'h3C;
    tick(2);
    check("gpio oe", 16'(pins_r.oe), 16'h000F);
    check("gpio out", 16'(pins_r.out & pins_r.oe), 16'h0005);
    rd("port read", SGC_ADDR_PORT, 16'h003C);
    tx_enable = 1'b1;
    txd = 1'b0;
    tick(2);
    check("txd", {14'h0000, pins_r.oe[7], pins_r.out[7]}, 16'h0002);
    txd = 1'b1;
    spi_out = '{master: 1'b1, enable: 1'b0, mosi: 1'b1, miso: 1'b0, sck: 1'b0, pcs: 4'hF};
    wr(SGC_ADDR_PINCTL, 2'b11, 16'h0F06);
    tick(2);
    check("txd high", {14'h0000, pins_r.oe[7], pins_r.out[7]}, 16'h0003);
    check("master oe", 16'(pins_r.oe[3:0]), 16'h0006);
    check("sck gpio", 16'(pins_r.out[2:1]), 16'h0003);
    check("miso in", 16'(spi_in_r.miso), 16'h0000);
    spi_out.enable = 1'b1;
    spi_out.mosi = 1'b0;
    pin_in = 8'h34;
    tick(2);
    check("sck spi", 16'(pins_r.out[2:1]), 16'h0000);
    check("mode fault", 16'(mode_fault_r), 16'h0001);
    spi_out.master = 1'b0;
    tick(2);
    check("slave in", {14'h0000, spi_in_r.mosi, spi_in_r.ss_n}, 16'h0002);
    tx_enable = 1'b0;
    $display("t_pins done");
  endtask

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    freeze = 1'b0;
    spi_boundary = 1'b0;
    spi_irq_req = 1'b0;
    async_irq_req = 1'b0;
    tx_enable = 1'b0;
    txd = 1'b1;
    pin_in = 8'hFF;
    spi_out = '0;
    err_count = 0;
    n_checks = 0;
    tick(20);
    reset_n = 1'b1;
    t_stop();
    t_regs();
    t_irq();
    t_freeze();
    t_pins();
    finish_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(40 * 5000);
    err_count++;
    finish_test();
  end
endmodule
